// ---- tmr_consts.vh ----
// Purpose: constants for the sixteen bit timer/counter
// Assumes: byte-wide register port, 100 MHz core clock
// Notes: offsets other than the control register are local choices
`ifndef TMR_CONSTS_VH
`define TMR_CONSTS_VH
// ****************************************
// register offsets
// ****************************************
`define OFS_CONTROL 8'h10
`define OFS_COUNT_LOW 8'h0e
`define OFS_COUNT_HIGH 8'h0f
`define OFS_FLAG 8'h0c
`define OFS_ENABLE 8'h8c
`define OFS_PORT_C 8'h07
`define OFS_PORT_C_DIR 8'h87
// ****************************************
// control fields
// ****************************************
`define CTL_RUN 0
`define CTL_SRC 1
`define CTL_NOSYNC 2
`define CTL_OSCEN 3
`define CTL_PS_LO 4
`define CTL_PS_HI 5
`define CTL_RESET 8'h00
`define CTL_MASK 8'h3f
`define FLAG_OVF 0
`define DIR_RESET 8'hff
// ****************************************
// timing
// ****************************************
`define INSTR_DIV 4
`endif

// ---- tmr_prescaler.v ----
// Purpose: selectable 1:1/1:2/1:4/1:8 divider of count ticks
// Assumes: tick is a one-cycle pulse
// Notes: clear wins over tick
`timescale 1ns/100ps
`default_nettype none
module tmr_prescaler (
    input wire clk,
    input wire rst_n,
    input wire clear,
    input wire tick,
    input wire [1:0] sel,
    output wire out_tick
);
    reg [2:0] cnt_q;
    reg [2:0] mask;
    always @* begin
        case (sel)
            2'b00: mask = 3'h0;
            2'b01: mask = 3'h1;
            2'b10: mask = 3'h3;
            default: mask = 3'h7;
        endcase
    end
    assign out_tick = tick && ((cnt_q & mask) == mask);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 3'h0;
        end else if (clear) begin
            cnt_q <= 3'h0;
        end else if (tick) begin
            cnt_q <= cnt_q + 3'h1;
        end
    end
endmodule // tmr_prescaler
`default_nettype wire

// ---- tmr_sync.v ----
// Purpose: two-stage synchroniser for the external count clock
// Assumes: input may be asynchronous to clk
// Notes: first stage feeds only the second
`timescale 1ns/100ps
`default_nettype none
module tmr_sync (
    input wire clk,
    input wire rst_n,
    input wire din,
    output reg dout
);
    reg meta_q;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule // tmr_sync
`default_nettype wire

// ---- timer16.v ----
// Purpose: sixteen bit timer/counter with prescaler and oscillator pin control
// Assumes: register port strobes are one cycle and synchronous to CLK
// Notes: counter data registers are cleared to zero whenever RST_N is asserted
//
// Notes on behaviour
// - count runs 0000h up to FFFFh, then wraps to zero
// - each wrap sets and holds overflow flag, flag register bit 0
// - interrupt request raised only while enable register bit 0 is set
// - control bit 1 selects timer (0) or counter (1)
// - timer operation counts once per instruction cycle, clock divided by four
// - sync control bit is ignored in timer operation
// - counter operation counts rising edges of external clock only
// - after enabling counter, first rising edge needs a prior falling edge
// - count advances only while run bit 0 is set; cleared freezes
// - special event trigger from either compare unit clears the count
// - oscillator enabled forces both pins input, reads zero, ignores direction
// - prescale field bits 5:4 divides by 1, 2, 4 or 8
// - counter mode synchronises when sync bit 0, unsynchronised when 1
// - oscillator enable bit 3 powers the oscillator; clear turns inverter off
// - count visible as separate read/write high and low bytes
// - any write to a count byte clears the prescaler
// - software count write beats a simultaneous special event clear
// - special event clear never sets the overflow flag
// - reset clears control register to 00h
//
// The implementer's own choice: strobed register access.
`include "tmr_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module timer16 #(
    parameter INSTR_DIV = `INSTR_DIV
) (
    input wire CLK,
    input wire RST_N,
    input wire [7:0] ADDR,
    input wire [7:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [7:0] RDATA,
    input wire SPECIAL_EVENT_1,
    input wire SPECIAL_EVENT_2,
    input wire OSC_INPUT_PIN_I,
    output wire OSC_INPUT_PIN_O,
    output wire OSC_INPUT_PIN_OE_N,
    input wire OSC_OUTPUT_PIN_I,
    output wire OSC_OUTPUT_PIN_O,
    output wire OSC_OUTPUT_PIN_OE_N,
    output wire OSC_INVERTER_ON,
    output wire OVERFLOW_IRQ
);
    // ****************************************
    // registers
    // ****************************************
    reg [7:0] ctl_q;
    reg [7:0] cnt_hi_q;
    reg [7:0] cnt_lo_q;
    reg ovf_flag_q;
    reg ovf_en_q;
    reg [7:0] port_q;
    reg [7:0] dir_q;
    reg [1:0] idiv_q;
    reg ext_prev_q;
    reg armed_q;
    reg run_prev_q;
    reg src_prev_q;
    wire run = ctl_q[`CTL_RUN];
    wire src_ext = ctl_q[`CTL_SRC];
    wire nosync = ctl_q[`CTL_NOSYNC];
    wire osc_en = ctl_q[`CTL_OSCEN];
    wire [1:0] ps_sel = ctl_q[`CTL_PS_HI:`CTL_PS_LO];
    wire wr_ctl = WR && (ADDR == `OFS_CONTROL);
    wire wr_lo = WR && (ADDR == `OFS_COUNT_LOW);
    wire wr_hi = WR && (ADDR == `OFS_COUNT_HIGH);
    wire wr_cnt = wr_lo || wr_hi;
    // ****************************************
    // external clock path
    // ****************************************
    // oscillator enabled takes the count input from the oscillator input pin
    wire ext_raw = osc_en ? OSC_INPUT_PIN_I : OSC_OUTPUT_PIN_I;
    wire ext_synced;
    tmr_sync u_sync (
        .clk(CLK),
        .rst_n(RST_N),
        .din(ext_raw),
        .dout(ext_synced)
    );
    // unsynchronised mode still needs one flop to sample the level; the
    // clock is single so true async counting is approximated
    reg ext_raw_q;
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ext_raw_q <= 1'b0;
        end else begin
            ext_raw_q <= ext_raw;
        end
    end
    wire ext_lvl = nosync ? ext_raw_q : ext_synced;
    wire ext_rise = ext_lvl && !ext_prev_q;
    wire ext_fall = !ext_lvl && ext_prev_q;
    // disarm whenever counting starts in counter mode; a later falling edge re-arms
    wire start_ext = src_ext && run && !(run_prev_q && src_prev_q);
    // ****************************************
    // tick source
    // ****************************************
    wire int_tick = (idiv_q == INSTR_DIV - 1);
    wire ext_tick = ext_rise && armed_q && !start_ext;
    wire src_tick = run && (src_ext ? ext_tick : int_tick);
    wire pre_tick;
    tmr_prescaler u_pre (
        .clk(CLK),
        .rst_n(RST_N),
        .clear(wr_cnt),
        .tick(src_tick),
        .sel(ps_sel),
        .out_tick(pre_tick)
    );
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            idiv_q <= 2'h0;
            ext_prev_q <= 1'b0;
            armed_q <= 1'b0;
            run_prev_q <= 1'b0;
            src_prev_q <= 1'b0;
        end else begin
            idiv_q <= int_tick ? 2'h0 : idiv_q + 2'h1;
            ext_prev_q <= ext_lvl;
            run_prev_q <= run;
            src_prev_q <= src_ext;
            if (start_ext) begin
                armed_q <= 1'b0;
            end else if (ext_fall) begin
                armed_q <= 1'b1;
            end
        end
    end
    // ****************************************
    // count pair
    // ****************************************
    wire [15:0] cnt = {cnt_hi_q, cnt_lo_q};
    wire [15:0] cnt_inc = cnt + 16'h0001;
    wire sev = SPECIAL_EVENT_1 || SPECIAL_EVENT_2;
    wire wrap = pre_tick && (cnt == 16'hffff) && !wr_cnt && !sev;
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_hi_q <= 8'h00;
            cnt_lo_q <= 8'h00;
        end else if (wr_cnt) begin
            // software write outranks the special event clear
            if (wr_hi) begin
                cnt_hi_q <= WDATA;
            end
            if (wr_lo) begin
                cnt_lo_q <= WDATA;
            end
        end else if (sev) begin
            cnt_hi_q <= 8'h00;
            cnt_lo_q <= 8'h00;
        end else if (pre_tick) begin
            cnt_hi_q <= cnt_inc[15:8];
            cnt_lo_q <= cnt_inc[7:0];
        end
    end
    // ****************************************
    // control, flags, port c
    // ****************************************
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctl_q <= `CTL_RESET;
            ovf_flag_q <= 1'b0;
            ovf_en_q <= 1'b0;
            port_q <= 8'h00;
            dir_q <= `DIR_RESET;
        end else begin
            if (wr_ctl) begin
                ctl_q <= WDATA & `CTL_MASK;
            end
            if (wrap) begin
                ovf_flag_q <= 1'b1; // set wins over clear
            end else if (WR && ADDR == `OFS_FLAG) begin
                ovf_flag_q <= WDATA[`FLAG_OVF];
            end
            if (WR && ADDR == `OFS_ENABLE) begin
                ovf_en_q <= WDATA[`FLAG_OVF];
            end
            if (WR && ADDR == `OFS_PORT_C) begin
                port_q <= WDATA;
            end
            if (WR && ADDR == `OFS_PORT_C_DIR) begin
                dir_q <= WDATA;
            end
        end
    end
    assign OVERFLOW_IRQ = ovf_flag_q && ovf_en_q;
    assign OSC_INVERTER_ON = osc_en;
    // direction 1 means input; enable is active low
    assign OSC_OUTPUT_PIN_OE_N = osc_en | dir_q[0];
    assign OSC_INPUT_PIN_OE_N = osc_en | dir_q[1];
    assign OSC_OUTPUT_PIN_O = port_q[0];
    assign OSC_INPUT_PIN_O = port_q[1];
    wire [1:0] pin_rd = osc_en ? 2'b00 : {OSC_INPUT_PIN_I, OSC_OUTPUT_PIN_I};
    // ****************************************
    // read port
    // ****************************************
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            if (ADDR == `OFS_CONTROL) begin
                RDATA <= ctl_q;
            end else if (ADDR == `OFS_COUNT_HIGH) begin
                RDATA <= cnt_hi_q;
            end else if (ADDR == `OFS_COUNT_LOW) begin
                RDATA <= cnt_lo_q;
            end else if (ADDR == `OFS_FLAG) begin
                RDATA <= {7'h00, ovf_flag_q};
            end else if (ADDR == `OFS_ENABLE) begin
                RDATA <= {7'h00, ovf_en_q};
            end else if (ADDR == `OFS_PORT_C) begin
                RDATA <= {6'h00, pin_rd};
            end else if (ADDR == `OFS_PORT_C_DIR) begin
                RDATA <= dir_q;
            end else begin
                RDATA <= 8'h00;
            end
        end else begin
            RDATA <= 8'h00;
        end
    end
endmodule // timer16
`default_nettype wire

// ---- timer16_checker.sv ----
// Purpose: port assertions for the sixteen bit timer/counter
// Assumes: register offsets from tmr_consts.vh
// Notes: flag and enable bits are seen only through the irq output
`include "tmr_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module timer16_checker #(
    parameter INSTR_DIV = 4
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic OSC_INPUT_PIN_OE_N,
    input wire logic OSC_OUTPUT_PIN_OE_N,
    input wire logic OSC_INVERTER_ON,
    input wire logic OVERFLOW_IRQ
);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    sequence s_en_set;
        WR && ADDR == `OFS_ENABLE && WDATA[0];
    endsequence
    sequence s_flag_set;
        WR && ADDR == `OFS_FLAG && WDATA[0];
    endsequence
    a_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data not zero outside read cycle");
    a_ctl_top_zero: assert property ($past(RD && ADDR == `OFS_CONTROL) |-> RDATA[7:6] == 2'b00)
        else $error("control bits 7:6 read nonzero");
    a_osc_pins_in: assert property (OSC_INVERTER_ON |-> OSC_INPUT_PIN_OE_N && OSC_OUTPUT_PIN_OE_N)
        else $error("oscillator pin driven while oscillator on");
    a_inv_follows: assert property (WR && ADDR == `OFS_CONTROL |=> OSC_INVERTER_ON == $past(WDATA[3]))
        else $error("inverter enable does not follow control bit 3");
    a_irq_holds: assert property (
        OVERFLOW_IRQ && !(WR && (ADDR == `OFS_FLAG || ADDR == `OFS_ENABLE)) |=> OVERFLOW_IRQ)
        else $error("overflow request dropped without software");
    a_irq_masked: assert property (WR && ADDR == `OFS_ENABLE && !WDATA[0] |=> !OVERFLOW_IRQ)
        else $error("overflow request raised while disabled");
    a_irq_armed: assert property (s_en_set ##1 !WR ##1 s_flag_set |=> OVERFLOW_IRQ)
        else $error("overflow request missing with flag and enable set");
    a_reset_state: assert property ($rose(RST_N) |->
        !OSC_INVERTER_ON && !OVERFLOW_IRQ && OSC_INPUT_PIN_OE_N && OSC_OUTPUT_PIN_OE_N)
        else $error("outputs not at reset state after reset");
endmodule // timer16_checker
bind timer16 timer16_checker #(.INSTR_DIV(INSTR_DIV)) u_chk (.CLK, .RST_N, .ADDR, .WDATA,
    .WR, .RD, .RDATA, .OSC_INPUT_PIN_OE_N, .OSC_OUTPUT_PIN_OE_N, .OSC_INVERTER_ON,
    .OVERFLOW_IRQ);
`default_nettype wire

// ---- ext_clock_src.sv ----
// Purpose: external count clock source for the two oscillator pins
// Assumes: pulse widths well above the core clock period
// Notes: only one pin moves per burst; the other stands low
`timescale 1ns/100ps
`default_nettype none
module ext_clock_src (
    output logic in_pin,
    output logic out_pin
);
    // ****************************************
    // pin drive
    // ****************************************
    logic use_in = 1'b0;
    logic lvl = 1'b0;
    assign in_pin = use_in & lvl;
    assign out_pin = !use_in & lvl;
    // steady level on one pin, for static pin reads
    task automatic set_level(input logic on_in, input logic v);
        use_in = on_in;
        lvl = v;
    endtask
    // idle low between bursts, so a burst always starts with a rising edge
    task automatic pulses(input logic on_in, input int n, input int half_ns);
        use_in = on_in;
        repeat (n) begin
            lvl = 1'b1;
            #(half_ns);
            lvl = 1'b0;
            #(half_ns);
        end
    endtask
endmodule // ext_clock_src
`default_nettype wire

// ---- test_timer16.sv ----
// Purpose: self-checking bench for the sixteen bit timer/counter
// Assumes: register offsets from tmr_consts.vh, 100 MHz clock
// Notes: timed counts allow one tick of slack for divider phase
`include "tmr_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module test_timer16;
    // ****************************************
    // bench
    // ****************************************
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [1:0] se = 2'b00;
    wire [7:0] rdata;
    wire irq, pin_in, pin_out, inv_on;
    wire [1:0] pin_o;
    wire [1:0] pin_oe_n;
    int error_cnt = 0;
    int samples_checked = 0;
    always #5 clk = ~clk;
    ext_clock_src u_ext_clock_src (.in_pin(pin_in), .out_pin(pin_out));
    timer16 u_timer16 (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_en),
        .RD(rd_en), .RDATA(rdata), .SPECIAL_EVENT_1(se[0]), .SPECIAL_EVENT_2(se[1]),
        .OSC_INPUT_PIN_I(pin_in), .OSC_INPUT_PIN_O(pin_o[1]), .OSC_INPUT_PIN_OE_N(pin_oe_n[1]),
        .OSC_OUTPUT_PIN_I(pin_out), .OSC_OUTPUT_PIN_O(pin_o[0]),
        .OSC_OUTPUT_PIN_OE_N(pin_oe_n[0]), .OSC_INVERTER_ON(inv_on), .OVERFLOW_IRQ(irq));
    task automatic wrap_up;
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g, input bit tol);
        samples_checked++;
        if (!(g === e || (tol && (g === e + 8'h01 || g === e - 8'h01)))) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] e, input bit tol);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), e, rdata, tol);
    endtask
    task automatic t_regs;
        reg_rd(`OFS_CONTROL, 8'h00, 0);
        reg_rd(8'h55, 8'h00, 0);
        reg_wr(`OFS_CONTROL, 8'hff);
        reg_rd(`OFS_CONTROL, 8'h3f, 0);
        reg_wr(`OFS_CONTROL, 8'h00);
        reg_wr(`OFS_COUNT_HIGH, 8'ha5);
        reg_rd(`OFS_COUNT_HIGH, 8'ha5, 0);
    endtask
    task automatic t_timer;
        for (int ps = 0; ps < 4; ps++) begin
            reg_wr(`OFS_COUNT_HIGH, 8'h00);
            reg_wr(`OFS_COUNT_LOW, 8'h00);
            reg_wr(`OFS_CONTROL, {2'b00, ps[1:0], 1'b0, ps[0], 2'b01});
            repeat (64) @(posedge clk);
            reg_wr(`OFS_CONTROL, 8'h00);
            reg_rd(`OFS_COUNT_LOW, 8'h10 >> ps, 1);
            reg_rd(`OFS_COUNT_LOW, 8'h10 >> ps, 1);
        end
    endtask
    task automatic t_wrap;
        reg_wr(`OFS_COUNT_HIGH, 8'hff);
        reg_wr(`OFS_COUNT_LOW, 8'hfe);
        reg_wr(`OFS_FLAG, 8'h00);
        reg_wr(`OFS_ENABLE, 8'h01);
        reg_wr(`OFS_CONTROL, 8'h01);
        repeat (12) @(posedge clk);
        reg_wr(`OFS_CONTROL, 8'h00);
        reg_rd(`OFS_COUNT_HIGH, 8'h00, 0);
        reg_rd(`OFS_FLAG, 8'h01, 0);
        chk("irq", 8'h01, {7'h00, irq}, 0);
        reg_wr(`OFS_ENABLE, 8'h00);
        #1;
        chk("irq", 8'h00, {7'h00, irq}, 0);
        reg_wr(`OFS_FLAG, 8'h00);
        reg_wr(`OFS_ENABLE, 8'h01);
        reg_wr(`OFS_FLAG, 8'h01);
        reg_wr(`OFS_FLAG, 8'h00);
    endtask
    task automatic t_event;
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= `OFS_COUNT_LOW;
        wdata <= 8'h80;
        se <= 2'b10;
        @(posedge clk);
        wr_en <= 1'b0;
        se <= 2'b00;
        reg_rd(`OFS_COUNT_LOW, 8'h80, 0);
        for (int k = 0; k < 2; k++) begin
            reg_wr(`OFS_COUNT_LOW, 8'h80);
            se <= 2'b01 << k;
            @(posedge clk);
            se <= 2'b00;
            reg_rd(`OFS_COUNT_LOW, 8'h00, 0);
        end
        reg_rd(`OFS_FLAG, 8'h00, 0);
    endtask
    task automatic t_port;
        reg_wr(`OFS_PORT_C_DIR, 8'hfc);
        reg_wr(`OFS_PORT_C, 8'h02);
        u_ext_clock_src.set_level(1'b0, 1'b1);
        #1;
        chk("pin data", 8'h02, {6'h00, pin_o}, 0);
        chk("pin oe_n", 8'h00, {6'h00, pin_oe_n}, 0);
        reg_rd(`OFS_PORT_C, 8'h01, 0);
        reg_wr(`OFS_CONTROL, 8'h08);
        #1;
        chk("pin oe_n", 8'h03, {6'h00, pin_oe_n}, 0);
        chk("inverter", 8'h01, {7'h00, inv_on}, 0);
        reg_rd(`OFS_PORT_C, 8'h00, 0);
        reg_wr(`OFS_CONTROL, 8'h00);
        #1;
        chk("inverter", 8'h00, {7'h00, inv_on}, 0);
        u_ext_clock_src.set_level(1'b0, 1'b0);
        reg_wr(`OFS_PORT_C_DIR, 8'hff);
    endtask
    task automatic t_counter;
        for (int m = 0; m < 3; m++) begin
            reg_wr(`OFS_COUNT_LOW, 8'h00);
            reg_wr(`OFS_CONTROL, m == 2 ? 8'h0b : (m == 1 ? 8'h07 : 8'h03));
            u_ext_clock_src.pulses(m == 2, 5, 43);
            repeat (6) @(posedge clk);
            reg_wr(`OFS_CONTROL, 8'h00);
            reg_rd(`OFS_COUNT_LOW, 8'h04, 0);
        end
    endtask
    initial begin
        #900000;
        error_cnt++;
        wrap_up;
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_timer;
        t_wrap;
        t_event;
        t_port;
        t_counter;
        wrap_up;
    end
endmodule // test_timer16
`default_nettype wire
